// ===== dmac_datapath.sv
`timescale 1ns/1ps
// Function
// - divides: signed fractional, and signed/unsigned integer in 32/16 and 16/16 forms
// - word divides take the same step count; dividend zero or sign extended first
// - whole divide including repeat setup finishes in 19 cycles
// - repeat executes its target one more time than the loaded count
// - a divide may pause for an interrupt and resume with context intact
// - quotient to quotient_reg, remainder to remainder_reg, operands from dividend/divisor
// - engine: 17x17 multiplier, barrel shifter, 40-bit adder, two accumulators, round, saturate
// - accumulator add, subtract and negate use only the accumulators
// - engine refuses work while a general ALU instruction runs; squared difference shares
// - configuration picks multiply format, sign, rounding, saturation enables and mode
// - multiplier signed or unsigned, scaled to 1.31 fraction or 32-bit integer
// - 16-bit operands zero or sign extended to 17 bits by signedness
// - 33-bit scaled product sign extended to 40 bits
// - fractional operands have radix after sign; 16x16 gives 1.31 product
// - same multiplier serves integer multiplies of any operand signedness mix
// - byte integer multiply gives 16 bits, word multiply gives 32 bits
// - 40-bit adder with sign extension, accumulator A or B as source and destination
// - load data may be scaled through the barrel shifter first
// - integers are two's complement, 16-bit range 0x8000 to 0x7fff
// - barrel shifter moves up to 15 right or 16 left in one cycle
module dmac_datapath
    import dmac_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic rep_load,
    input wire logic [REP_W-1:0] rep_count,
    input wire logic rep_hold,
    output logic rep_active,
    output logic rep_exec,
    output logic [REP_W-1:0] repeat_counter,
    input wire logic div_req,
    input wire dmac_div_kind_type div_kind,
    input wire logic [DATA_W-1:0] dividend_reg,
    input wire logic [DATA_W-1:0] dividend_hi_reg,
    input wire logic [DATA_W-1:0] divisor_reg,
    output logic [DATA_W-1:0] quotient_reg,
    output logic [DATA_W-1:0] remainder_reg,
    output logic div_done,
    input wire logic mac_valid,
    input wire dmac_mac_op_type mac_op,
    input wire logic alu_busy,
    input wire logic acc_target_b,
    input wire logic [DATA_W-1:0] x_data,
    input wire logic [DATA_W-1:0] y_data,
    input wire logic [DATA_W-1:0] load_data,
    input wire logic [5:0] shift_amt,
    input wire logic wb_req,
    input wire logic frac_mode,
    input wire logic sign_mode_select,
    input wire logic round_mode_select,
    input wire logic acc_a_sat_enable,
    input wire logic acc_b_sat_enable,
    input wire logic data_write_sat_enable,
    input wire logic acc_sat_mode,
    input wire logic int_mul_a_signed,
    input wire logic int_mul_b_signed,
    input wire logic int_mul_byte,
    output logic [ACC_W-1:0] accumulator_a,
    output logic [ACC_W-1:0] accumulator_b,
    output logic [DATA_W-1:0] wb_data,
    output logic wb_valid,
    output logic [31:0] int_product,
    output logic int_product_valid,
    output logic mac_refused
);
    dmac_div_if div_bus();

    logic rep_active_q;
    logic [REP_W-1:0] repeat_counter_q;
    logic div_active_q;
    dmac_div_kind_type div_kind_q;
    logic exec;

    // repeat engine: count+1 executions, frozen while an interrupt holds it
    assign exec = rep_active_q && !rep_hold;

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            rep_active_q <= 1'b0;
            repeat_counter_q <= DIV_LAST_CNT;
        end else if (rep_load && !rep_active_q) begin
            rep_active_q <= 1'b1;
            repeat_counter_q <= rep_count;
        end else if (exec) begin
            if (repeat_counter_q == DIV_LAST_CNT) begin
                rep_active_q <= 1'b0;
            end else begin
                repeat_counter_q <= repeat_counter_q - 14'h0001;
            end
        end
    end

    // divider follows the repeat counter and relies on a count of 17 being loaded
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            div_active_q <= 1'b0;
            div_kind_q <= frac_divide_op;
        end else if (rep_load && !rep_active_q) begin
            div_active_q <= div_req;
            div_kind_q <= div_kind;
        end else if (exec && repeat_counter_q == DIV_LAST_CNT) begin
            div_active_q <= 1'b0;
        end
    end

    assign div_bus.step = exec && div_active_q;
    assign div_bus.first = repeat_counter_q == DIV_FIRST_CNT;
    assign div_bus.last = repeat_counter_q == DIV_LAST_CNT;
    assign div_bus.kind = div_kind_q;
    assign div_bus.dividend_lo = dividend_reg;
    assign div_bus.dividend_hi = dividend_hi_reg;
    assign div_bus.divisor = divisor_reg;

    dmac_divider u_dmac_divider (
        .core_clk(core_clk),
        .rst_b(rst_b),
        .div(div_bus)
    );

    assign quotient_reg = div_bus.quotient;
    assign remainder_reg = div_bus.remainder;
    assign div_done = div_bus.done;
    assign rep_active = rep_active_q;
    assign rep_exec = exec;
    assign repeat_counter = repeat_counter_q;

    // multiply-accumulate engine
    logic go;
    logic [ACC_W-1:0] acc_a_q;
    logic [ACC_W-1:0] acc_b_q;
    logic [ACC_W-1:0] tgt;
    logic [ACC_W-1:0] oth;
    logic [MUL_W-1:0] ma;
    logic [MUL_W-1:0] mb;
    logic [MUL_W-1:0] sq_diff;
    logic [33:0] prod;
    logic [PROD_W-1:0] scaled;
    logic [ACC_W-1:0] mul40;
    logic [ACC_W-1:0] shift_src;
    logic [ACC_W-1:0] shifted;
    logic [5:0] sh_n;
    logic [ACC_W-1:0] lhs;
    logic [ACC_W-1:0] rhs;
    logic subtract;
    logic [ACC_W:0] sum;
    logic ovf39;
    logic ovf31;
    logic sat_en;
    logic [ACC_W-1:0] result;
    logic acc_we;
    logic wb_allowed;

    assign go = mac_valid && !alu_busy;
    assign tgt = acc_target_b ? acc_b_q : acc_a_q;
    assign oth = acc_target_b ? acc_a_q : acc_b_q;
    // the difference comes from a 17-bit subtractor in this module, inside the same instruction
    assign sq_diff = {x_data[15], x_data} - {y_data[15], y_data};

    always_comb begin
        ma = {!sign_mode_select && x_data[15], x_data};
        mb = {!sign_mode_select && y_data[15], y_data};
        unique case (mac_op)
            square_accum_op: mb = ma;
            squared_diff_op, squared_diff_accum_op: begin
                ma = sq_diff;
                mb = sq_diff;
            end
            integer_multiply_op: begin
                if (int_mul_byte) begin
                    ma = {{9{int_mul_a_signed && x_data[7]}}, x_data[7:0]};
                    mb = {{9{int_mul_b_signed && y_data[7]}}, y_data[7:0]};
                end else begin
                    ma = {int_mul_a_signed && x_data[15], x_data};
                    mb = {int_mul_b_signed && y_data[15], y_data};
                end
            end
            default: begin
            end
        endcase
    end

    assign prod = $signed(ma) * $signed(mb);
    // fractional scaling drops the duplicated sign bit to form 1.31
    assign scaled = frac_mode ? {prod[31:0], 1'b0} : prod[PROD_W-1:0];
    assign mul40 = {{(ACC_W-PROD_W){scaled[PROD_W-1]}}, scaled};

    // positive amount shifts right, negative left; out-of-range amounts clamp
    assign shift_src = (mac_op == acc_shift_op) ? tgt :
                       {{8{load_data[15]}}, load_data, 16'h0000};
    always_comb begin
        if (!shift_amt[5]) begin
            sh_n = (shift_amt > SHIFT_RIGHT_MAX) ? SHIFT_RIGHT_MAX : shift_amt;
            shifted = ACC_W'($signed(shift_src) >>> sh_n);
        end else begin
            sh_n = 6'(-shift_amt);
            sh_n = (sh_n > SHIFT_LEFT_MAX) ? SHIFT_LEFT_MAX : sh_n;
            shifted = shift_src << sh_n;
        end
    end

    always_comb begin
        lhs = ACC_ZERO;
        rhs = ACC_ZERO;
        subtract = 1'b0;
        unique case (mac_op)
            clr_op: lhs = ACC_ZERO;
            mult_op, squared_diff_op: rhs = mul40;
            neg_mult_op: begin
                rhs = mul40;
                subtract = 1'b1;
            end
            mult_accum_op, square_accum_op, squared_diff_accum_op: begin
                lhs = tgt;
                rhs = mul40;
            end
            mult_subtract_op: begin
                lhs = tgt;
                rhs = mul40;
                subtract = 1'b1;
            end
            acc_add_op: begin
                lhs = tgt;
                rhs = oth;
            end
            acc_sub_op: begin
                lhs = tgt;
                rhs = oth;
                subtract = 1'b1;
            end
            acc_neg_op: begin
                rhs = tgt;
                subtract = 1'b1;
            end
            load_accumulator_op: rhs = shifted;
            default: lhs = tgt;
        endcase
    end

    assign sum = subtract ? {lhs[ACC_W-1], lhs} - {rhs[ACC_W-1], rhs} :
                            {lhs[ACC_W-1], lhs} + {rhs[ACC_W-1], rhs};
    assign ovf39 = sum[ACC_W] ^ sum[ACC_W-1];
    assign ovf31 = !((&sum[ACC_W:ACC_GUARD_LSB]) || !(|sum[ACC_W:ACC_GUARD_LSB]));
    assign sat_en = acc_target_b ? acc_b_sat_enable : acc_a_sat_enable;

    always_comb begin
        if (mac_op == acc_shift_op) begin
            result = shifted;
        end else if (sat_en && acc_sat_mode && ovf39) begin
            result = sum[ACC_W] ? SAT39_NEG : SAT39_POS;
        end else if (sat_en && !acc_sat_mode && ovf31) begin
            result = sum[ACC_W] ? SAT31_NEG : SAT31_POS;
        end else begin
            result = sum[ACC_W-1:0];
        end
    end

    assign acc_we = go && mac_op != acc_prefetch_move_op && mac_op != integer_multiply_op;

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            acc_a_q <= ACC_ZERO;
            acc_b_q <= ACC_ZERO;
        end else if (acc_we && acc_target_b) begin
            acc_b_q <= result;
        end else if (acc_we) begin
            acc_a_q <= result;
        end
    end

    // write-back: rounded high word of the non-target accumulator
    logic [DATA_W-1:0] oth_lo;
    logic [DATA_W-1:0] oth_hi;
    logic round_inc;
    logic [DATA_W:0] rounded;
    logic wb_ovf;
    logic [DATA_W-1:0] wb_d;

    assign wb_allowed = mac_op == clr_op || mac_op == mult_accum_op ||
                        mac_op == acc_prefetch_move_op || mac_op == mult_subtract_op;
    assign oth_lo = oth[ACC_HI_LSB-1:0];
    assign oth_hi = oth[ACC_GUARD_LSB:ACC_HI_LSB];
    assign round_inc = (round_mode_select && oth_lo == ROUND_HALF) ? oth_hi[0] :
                       oth_lo[15];
    assign rounded = {oth_hi[15], oth_hi} + {16'h0000, round_inc};
    // a guard-bit overflow or a round carry into the sign both clamp when enabled
    assign wb_ovf = (rounded[DATA_W] ^ rounded[DATA_W-1]) ||
                    !((&oth[ACC_W-1:ACC_GUARD_LSB]) || !(|oth[ACC_W-1:ACC_GUARD_LSB]));
    assign wb_d = (data_write_sat_enable && wb_ovf) ? (oth[ACC_W-1] ? WB_NEG : WB_POS) :
                  rounded[DATA_W-1:0];

    logic [DATA_W-1:0] wb_data_q;
    logic wb_valid_q;
    logic [31:0] int_product_q;
    logic int_product_valid_q;
    logic mac_refused_q;

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            wb_data_q <= 16'h0000;
            wb_valid_q <= 1'b0;
        end else begin
            wb_valid_q <= go && wb_req && wb_allowed;
            if (go && wb_req && wb_allowed) begin
                wb_data_q <= wb_d;
            end
        end
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            int_product_q <= 32'h00000000;
            int_product_valid_q <= 1'b0;
        end else begin
            int_product_valid_q <= go && mac_op == integer_multiply_op;
            if (go && mac_op == integer_multiply_op) begin
                int_product_q <= int_mul_byte ? {16'h0000, prod[15:0]} : prod[31:0];
            end
        end
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            mac_refused_q <= 1'b0;
        end else begin
            mac_refused_q <= mac_valid && alu_busy;
        end
    end

    assign accumulator_a = acc_a_q;
    assign accumulator_b = acc_b_q;
    assign wb_data = wb_data_q;
    assign wb_valid = wb_valid_q;
    assign int_product = int_product_q;
    assign int_product_valid = int_product_valid_q;
    assign mac_refused = mac_refused_q;

    // helper: executions seen since the last repeat load
    logic [REP_W:0] exec_seen_q;
    logic [REP_W:0] loaded_q;
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            exec_seen_q <= 15'h0000;
            loaded_q <= 15'h0000;
        end else if (rep_load && !rep_active_q) begin
            exec_seen_q <= 15'h0000;
            loaded_q <= {1'b0, rep_count};
        end else if (exec) begin
            exec_seen_q <= exec_seen_q + 15'h0001;
        end
    end

    sequence div_launch;
        rep_load && !rep_active_q && div_req && rep_count == DIV_FIRST_CNT;
    endsequence
    sequence div_run_free;
        (!rep_hold)[*8] ##1 (!rep_hold)[*8] ##1 (!rep_hold)[*2];
    endsequence

    chk_div_nineteen_cycles: assert property (
        @(posedge core_clk) disable iff (!rst_b)
        div_launch ##1 div_run_free |=> div_done)
        else $error("divide did not complete in 19 cycles");

    chk_repeat_count_plus: assert property (
        @(posedge core_clk) disable iff (!rst_b)
        $fell(rep_active_q) |-> exec_seen_q == loaded_q + 15'h0001)
        else $error("repeat did not run count plus one times");

    chk_hold_freezes_div: assert property (
        @(posedge core_clk) disable iff (!rst_b)
        rep_active_q && rep_hold |=> rep_active_q && $stable(repeat_counter_q) && !div_done)
        else $error("held repeat advanced");

    chk_busy_refuses: assert property (
        @(posedge core_clk) disable iff (!rst_b)
        mac_valid && alu_busy |=> mac_refused && $stable(acc_a_q) && $stable(acc_b_q))
        else $error("engine ran beside a busy ALU");

    chk_clear_acc_a: assert property (
        @(posedge core_clk) disable iff (!rst_b)
        go && mac_op == clr_op && !acc_target_b |=> acc_a_q == ACC_ZERO)
        else $error("clear left accumulator A nonzero");

    chk_wb_only_allowed: assert property (
        @(posedge core_clk) disable iff (!rst_b)
        wb_valid |-> $past(go && wb_allowed && wb_req))
        else $error("write-back from a barred operation");

    chk_acc_negate: assert property (
        @(posedge core_clk) disable iff (!rst_b)
        go && mac_op == acc_neg_op && !acc_target_b && !acc_a_sat_enable
        |=> acc_a_q == ACC_W'(-$past(acc_a_q)))
        else $error("negate did not negate accumulator A");

    chk_unsigned_mult_ext: assert property (
        @(posedge core_clk) disable iff (!rst_b)
        go && mac_op == mult_op && sign_mode_select && !frac_mode && acc_target_b &&
        !acc_b_sat_enable
        |=> acc_b_q == {24'h000000, $past(x_data)} * {24'h000000, $past(y_data)})
        else $error("unsigned multiply not zero extended");

    chk_byte_product: assert property (
        @(posedge core_clk) disable iff (!rst_b)
        go && mac_op == integer_multiply_op && int_mul_byte
        |=> int_product_valid ##0 int_product[31:16] == 16'h0000)
        else $error("byte multiply wrote more than 16 bits");
endmodule

// ===== dmac_pkg.sv
package dmac_pkg;
    localparam int DATA_W = 16;
    localparam int ACC_W = 40;
    localparam int MUL_W = 17;
    localparam int PROD_W = 33;
    localparam int REP_W = 14;
    localparam int ACC_HI_LSB = 16;
    localparam int ACC_GUARD_LSB = 31;

    // a divide runs 18 executions: count 17, one extend step, 16 trial steps, one fix-up step
    localparam logic [REP_W-1:0] DIV_FIRST_CNT = 14'h0011;
    localparam logic [REP_W-1:0] DIV_LAST_CNT = 14'h0000;

    localparam logic [5:0] SHIFT_RIGHT_MAX = 6'h0f;
    localparam logic [5:0] SHIFT_LEFT_MAX = 6'h10;

    localparam logic [ACC_W-1:0] ACC_ZERO = 40'h0000000000;
    localparam logic [ACC_W-1:0] SAT39_POS = 40'h7fffffffff;
    localparam logic [ACC_W-1:0] SAT39_NEG = 40'h8000000000;
    localparam logic [ACC_W-1:0] SAT31_POS = 40'h007fffffff;
    localparam logic [ACC_W-1:0] SAT31_NEG = 40'hff80000000;
    localparam logic [DATA_W-1:0] WB_POS = 16'h7fff;
    localparam logic [DATA_W-1:0] WB_NEG = 16'h8000;
    localparam logic [DATA_W-1:0] ROUND_HALF = 16'h8000;

    typedef enum logic [2:0] {
        frac_divide_op,
        signed_long_divide_op,
        unsigned_long_divide_op,
        signed_word_divide_op,
        unsigned_word_divide_op
    } dmac_div_kind_type;

    typedef enum logic [3:0] {
        clr_op,
        mult_op,
        neg_mult_op,
        mult_accum_op,
        mult_subtract_op,
        square_accum_op,
        squared_diff_op,
        squared_diff_accum_op,
        acc_prefetch_move_op,
        acc_add_op,
        acc_sub_op,
        acc_neg_op,
        load_accumulator_op,
        acc_shift_op,
        integer_multiply_op
    } dmac_mac_op_type;
endpackage

// ===== dmac_div_if.sv
`timescale 1ns/1ps
interface dmac_div_if;
    import dmac_pkg::*;
    logic step;
    logic first;
    logic last;
    dmac_div_kind_type kind;
    logic [DATA_W-1:0] dividend_lo;
    logic [DATA_W-1:0] dividend_hi;
    logic [DATA_W-1:0] divisor;
    logic [DATA_W-1:0] quotient;
    logic [DATA_W-1:0] remainder;
    logic done;
    modport ctrl(output step, first, last, kind, dividend_lo, dividend_hi, divisor,
                 input quotient, remainder, done);
    modport unit(input step, first, last, kind, dividend_lo, dividend_hi, divisor,
                 output quotient, remainder, done);
endinterface

// ===== dmac_divider.sv
`timescale 1ns/1ps
module dmac_divider
    import dmac_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst_b,
    dmac_div_if.unit div
);
    logic signed_op;
    logic [31:0] dvd_raw;
    logic [31:0] dvd_mag;
    logic [DATA_W-1:0] dsr_mag;
    logic [DATA_W-1:0] part_q;
    logic [DATA_W-1:0] work_q;
    logic [DATA_W-1:0] dsr_q;
    logic qneg_q;
    logic rneg_q;
    logic [DATA_W-1:0] quotient_q;
    logic [DATA_W-1:0] remainder_q;
    logic done_q;
    logic [DATA_W:0] trial;
    logic [DATA_W:0] diff;
    logic fits;

    assign signed_op = (div.kind != unsigned_long_divide_op) &&
                       (div.kind != unsigned_word_divide_op);

    always_comb begin
        unique case (div.kind)
            frac_divide_op: dvd_raw = {div.dividend_lo[15], div.dividend_lo, 15'h0000};
            signed_long_divide_op: dvd_raw = {div.dividend_hi, div.dividend_lo};
            unsigned_long_divide_op: dvd_raw = {div.dividend_hi, div.dividend_lo};
            signed_word_divide_op: dvd_raw = {{16{div.dividend_lo[15]}}, div.dividend_lo};
            unsigned_word_divide_op: dvd_raw = {16'h0000, div.dividend_lo};
            default: dvd_raw = 32'h00000000;
        endcase
    end

    assign dvd_mag = (signed_op && dvd_raw[31]) ? 32'(-dvd_raw) : dvd_raw;
    assign dsr_mag = (signed_op && div.divisor[15]) ? 16'(-div.divisor) : div.divisor;
    assign trial = {part_q, work_q[15]};
    assign diff = trial - {1'b0, dsr_q};
    assign fits = trial >= {1'b0, dsr_q};

    // restoring steps on magnitudes; signs are applied once in the final step
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            part_q <= 16'h0000;
            work_q <= 16'h0000;
            dsr_q <= 16'h0000;
            qneg_q <= 1'b0;
            rneg_q <= 1'b0;
        end else if (div.step && div.first) begin
            part_q <= dvd_mag[31:16];
            work_q <= dvd_mag[15:0];
            dsr_q <= dsr_mag;
            qneg_q <= signed_op && (dvd_raw[31] ^ div.divisor[15]);
            rneg_q <= signed_op && dvd_raw[31];
        end else if (div.step && !div.last) begin
            part_q <= fits ? diff[DATA_W-1:0] : trial[DATA_W-1:0];
            work_q <= {work_q[14:0], fits};
        end
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            quotient_q <= 16'h0000;
            remainder_q <= 16'h0000;
            done_q <= 1'b0;
        end else begin
            done_q <= div.step && div.last;
            if (div.step && div.last) begin
                quotient_q <= qneg_q ? 16'(-work_q) : work_q;
                remainder_q <= rneg_q ? 16'(-part_q) : part_q;
            end
        end
    end

    assign div.quotient = quotient_q;
    assign div.remainder = remainder_q;
    assign div.done = done_q;

    chk_word_zero_extend: assert property (
        @(posedge core_clk) disable iff (!rst_b)
        div.step && div.first && div.kind == unsigned_word_divide_op |=> part_q == 16'h0000)
        else $error("unsigned word divide did not zero-extend its dividend");

    chk_rem_below_divisor: assert property (
        @(posedge core_clk) disable iff (!rst_b)
        div.step && div.last && !rneg_q && dsr_q != 16'h0000 |=> remainder_q < dsr_q)
        else $error("remainder not below divisor magnitude");
endmodule

// ===== dmac_seq_model.sv
`timescale 1ns/1ps
module dmac_seq_model
    import dmac_pkg::*;
(
    input wire logic core_clk,
    input wire logic go,
    output logic rep_load,
    output logic [REP_W-1:0] rep_count
);
    initial rep_load = 1'b0;
    initial rep_count = DIV_LAST_CNT;
    // count is junk outside a load, so a late latch would show up
    always @(posedge core_clk) begin
        rep_load <= go;
        rep_count <= go ? DIV_FIRST_CNT : ~DIV_FIRST_CNT;
    end
endmodule

// ===== test_divide_and_dsp_mac_datapath.sv
`timescale 1ns/1ps
module test_divide_and_dsp_mac_datapath
    import dmac_pkg::*;
;
    logic core_clk, rst_b, go, rep_load, rep_hold, div_req, div_done, mac_valid;
    logic [12:0] cfg;
    logic [REP_W-1:0] rep_count;
    logic [DATA_W-1:0] dividend_reg, dividend_hi_reg, divisor_reg, x_data, y_data;
    logic [DATA_W-1:0] quotient_reg, remainder_reg;
    logic [ACC_W-1:0] accumulator_a, accumulator_b;
    logic [31:0] int_product;
    logic rep_active, rep_exec, wb_valid, int_product_valid, mac_refused;
    logic [REP_W-1:0] repeat_counter;
    logic [DATA_W-1:0] wb_data;
    dmac_div_kind_type div_kind;
    dmac_mac_op_type mac_op;
    int err_total, n_checks, cyc;
    dmac_seq_model u_dmac_seq_model(.core_clk, .go, .rep_load, .rep_count);
    dmac_datapath u_dmac_datapath(.core_clk, .rst_b, .rep_load, .rep_count, .rep_hold,
        .rep_active, .rep_exec, .repeat_counter, .div_req, .div_kind, .dividend_reg,
        .dividend_hi_reg, .divisor_reg, .quotient_reg, .remainder_reg, .div_done, .mac_valid,
        .mac_op, .alu_busy(cfg[3]), .acc_target_b(cfg[0]), .x_data, .y_data,
        .load_data(x_data), .shift_amt(y_data[5:0]), .wb_req(cfg[4]), .frac_mode(cfg[2]),
        .sign_mode_select(cfg[1]), .round_mode_select(cfg[8]), .acc_a_sat_enable(cfg[9]),
        .acc_b_sat_enable(cfg[10]), .data_write_sat_enable(cfg[11]), .acc_sat_mode(cfg[12]),
        .int_mul_a_signed(cfg[5]), .int_mul_b_signed(cfg[6]), .int_mul_byte(cfg[7]),
        .accumulator_a, .accumulator_b, .wb_data, .wb_valid, .int_product,
        .int_product_valid, .mac_refused);
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        if (cyc == 2000) begin
            err_total++;
            wrap_up();
        end
    end
    task automatic check(input logic [39:0] seen, input logic [39:0] exp);
        n_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic run_div(input dmac_div_kind_type k, input logic [47:0] opd,
        input logic [31:0] exp, input int h);
        int n;
        n = 0;
        @(posedge core_clk);
        div_kind <= k;
        {dividend_hi_reg, dividend_reg, divisor_reg} <= opd;
        go <= 1'b1;
        @(posedge core_clk);
        go <= 1'b0;
        do begin
            @(posedge core_clk);
            rep_hold <= (n >= 4 && n < 4 + h);
            #1;
            n++;
            if (n == 5 && h > 0) check({39'h0, rep_exec}, 40'h0);
        end while (div_done !== 1'b1 && n < 40);
        check(40'(n), 40'(19 + h));
        check({25'h0, rep_active, repeat_counter}, 40'h0);
        check({8'h00, quotient_reg, remainder_reg}, {8'h00, exp});
        $display("divide test end");
    endtask
    task automatic run_mac(input dmac_mac_op_type op, input logic [12:0] c,
        input logic [31:0] xy, input logic [39:0] exp);
        @(posedge core_clk);
        mac_op <= op;
        cfg <= c;
        {x_data, y_data} <= xy;
        mac_valid <= 1'b1;
        @(posedge core_clk);
        mac_valid <= 1'b0;
        #1;
        check(op == integer_multiply_op ? {8'h00, int_product} :
            c[0] ? accumulator_b : accumulator_a, exp);
        $display("mac test end");
    endtask
    initial begin
        {rst_b, go, rep_hold, mac_valid, cfg} = 17'h00000;
        div_req = 1'b1;
        div_kind = signed_word_divide_op;
        mac_op = clr_op;
        {dividend_hi_reg, dividend_reg, divisor_reg, x_data, y_data} = 80'h0;
        repeat (4) @(posedge core_clk);
        rst_b <= 1'b1;
        run_div(signed_word_divide_op, 48'h0000_fff9_0002, 32'hfffd_ffff, 0);
        run_div(unsigned_word_divide_op, 48'h0000_fffe_0010, 32'h0fff_000e, 0);
        run_div(signed_long_divide_op, 48'hffff_fff9_0002, 32'hfffd_ffff, 3);
        run_div(unsigned_long_divide_op, 48'h0001_0000_0003, 32'h5555_0001, 0);
        run_div(frac_divide_op, 48'h0000_2000_4000, 32'h4000_0000, 0);
        run_mac(clr_op, 13'h0000, 32'h0, 40'h0);
        run_mac(mult_op, 13'h0000, 32'h0003_fffe, 40'hfffffffffa);
        run_mac(mult_accum_op, 13'h0000, 32'h0003_0002, 40'h0);
        run_mac(mult_op, 13'h0003, 32'hffff_0002, 40'h1fffe);
        run_mac(mult_op, 13'h0004, 32'h4000_4000, 40'h20000000);
        run_mac(acc_neg_op, 13'h0000, 32'h0, 40'hffe0000000);
        run_mac(mult_op, 13'h0008, 32'h0001_0001, 40'hffe0000000);
        check({39'h0, mac_refused}, 40'h1);
        run_mac(integer_multiply_op, 13'h0060, 32'h0003_fffe, 40'hfffffffa);
        run_mac(integer_multiply_op, 13'h0080, 32'h00ff_0002, 40'h01fe);
        check({39'h0, int_product_valid}, 40'h1);
        run_mac(acc_add_op, 13'h0000, 32'h0, 40'hffe001fffe);
        run_mac(acc_sub_op, 13'h0001, 32'h0, 40'h0020000000);
        run_mac(load_accumulator_op, 13'h0000, 32'h1234_0004, 40'h0001234000);
        run_mac(acc_shift_op, 13'h0000, 32'h0000_003f, 40'h0002468000);
        run_mac(squared_diff_op, 13'h0010, 32'h0005_0002, 40'h9);
        check({39'h0, wb_valid}, 40'h0);
        run_mac(squared_diff_accum_op, 13'h0000, 32'h0001_0003, 40'hd);
        run_mac(mult_subtract_op, 13'h0010, 32'h0002_0002, 40'h9);
        check({23'h0, wb_valid, wb_data}, 40'h12000);
        run_mac(square_accum_op, 13'h0000, 32'h0003_0000, 40'h12);
        run_mac(neg_mult_op, 13'h0000, 32'h0002_0003, 40'hfffffffffa);
        run_mac(acc_prefetch_move_op, 13'h0010, 32'h0, 40'hfffffffffa);
        check({23'h0, wb_valid, wb_data}, 40'h12000);
        run_mac(clr_op, 13'h0000, 32'h0, 40'h0);
        wrap_up();
    end
endmodule
